// file: inc/asu_pkg.sv
// package: constants and carriers for the automatic sleep unit
package asu_pkg;
  // power_ctl_reg_0 field positions
  localparam int APD_EN_BIT     = 1;
  localparam int TURBO_OFF_BIT  = 3;
  localparam int CLK_BLOCK_BIT  = 4;
  // power_ctl_reg_2 field positions
  localparam int BLK_CNTL0_BIT  = 2;
  localparam int BLK_CNTL1_BIT  = 3;
  localparam int BLK_CNTL2_BIT  = 4;
  localparam int BLK_STROBE_BIT = 5;
  localparam int BLK_DBE_BIT    = 6;
  // reset values and idle period
  localparam logic [7:0] PWR_REG_RESET = 8'h00;
  localparam logic [3:0] IDLE_PERIODS  = 4'hf;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } asu_bus_t;

  typedef struct packed {
    logic strobe;
    logic clk;
    logic cntl0;
    logic cntl1;
    logic cntl2;
    logic dbe;
  } asu_pld_in_t;
endpackage

// file: rtl/asu_idle_counter.sv
// idle counter: counts common clock periods while strobe rests
`timescale 1ns/1ns
module asu_idle_counter (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic strobeActivity,
  input  wire logic clkRise,
  output logic      sleepAssert
);
  import asu_pkg::*;

  typedef struct packed {
    logic [3:0] count;
    logic       sleep;
  } asu_cnt_state_t;

  asu_cnt_state_t state;
  asu_cnt_state_t next_state;

  // activity clears at once; only unbroken idle reaches fifteen
  always_comb begin
    next_state = state;
    if (!enable || strobeActivity) begin // RQ16
      next_state.count = 4'h0;
      next_state.sleep = 1'b0;
    end else if (clkRise && state.count != IDLE_PERIODS) begin // RQ12
      next_state.count = state.count + 4'h1;
      if (state.count + 4'h1 == IDLE_PERIODS) begin
        next_state.sleep = 1'b1; // RQ1
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sleepAssert = state.sleep;
endmodule // asu_idle_counter

// file: rtl/asu_auto_sleep_unit.sv
// auto sleep unit: power down control, gating and memory select
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: when enabled, power down follows an idle period of the address strobe.
// RQ2: in power down host address and data are gated and every memory is deselected.
// RQ3: in power down unblocked toggling array inputs still keep the arrays active. The code gates the strobe to the arrays in power down even when unblocked.
// RQ4: chip select is active low and high deselects flash, static RAM and control space.
// RQ5: chip select deselect blocks no signal and leaves the logic arrays running.
// RQ6: each memory stands by when its inputs are stable and wakes on any change.
// RQ7: host writes of the power registers set blocking bits that stop signals to the arrays.
// RQ8: a bit of register 0 disables turbo, which is on by default.
// RQ9: with turbo off the arrays stand by when no input changes.
// RQ10: port D pin 0 in its dedicated use is the address strobe.
// RQ11: port D pin 1 in its dedicated use is the common clock for arrays and counter.
// RQ12: the counter counts clock periods while strobe idles and asserts sleep after fifteen.
// RQ13: power down ends on strobe pulsing, chip select low, or reset returning high.
// RQ14: register 0 bit 1 enables auto sleep, bit 3 turns turbo off, bit 4 blocks the clock.
// RQ15: power registers clear only at power up, not on later resets.
// RQ16: any strobe activity clears the idle counter at once.
// RQ17: blocking the clock from the arrays does not stop the idle counter.
module asu_auto_sleep_unit (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            porN,
  input  wire logic            pin0Dedicated,
  input  wire logic            pin1Dedicated,
  input  wire logic            portdPin0,
  input  wire logic            portdPin1,
  input  wire logic            portdPin2,
  input  wire logic            strobeIdleLevel,
  input  wire logic            regWrite,
  input  wire logic            regSel,
  input  wire logic [7:0]      regWdata,
  input  wire asu_pkg::asu_bus_t hostBus,
  input  wire logic            cntl0,
  input  wire logic            cntl1,
  input  wire logic            cntl2,
  input  wire logic            dbe,
  output asu_pkg::asu_bus_t    memBus,
  output asu_pkg::asu_pld_in_t pldIn,
  output logic                 flashSel,
  output logic                 sramSel,
  output logic                 ctlSpaceSel,
  output logic                 memStandby,
  output logic                 pldStandby,
  output logic                 turboOn,
  output logic                 sleepState,
  output logic [7:0]           powerCtlReg0,
  output logic [7:0]           powerCtlReg2
);
  import asu_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] pin0Sync;
    logic [1:0] pin1Sync;
    logic [1:0] pin2Sync;
    logic       pin0Last;
    logic       pin1Last;
    asu_bus_t   busLast;
    asu_bus_t   memOut;
    asu_pld_in_t pldOut;
    logic       pldLastChg;
    logic       sleep;
    logic       wasReset;
  } asu_state_t;

  asu_state_t state;
  asu_state_t next_state;
  // power registers sit apart from state: they answer to porN, not rst
  logic [7:0] pwrReg0;
  logic [7:0] pwrReg2;
  logic [7:0] next_pwrReg0;
  logic [7:0] next_pwrReg2;
  logic       counterSleep;
  logic       strobeAct;
  logic       clkRise;
  logic       csHigh;
  logic       strobeLvl;
  logic       clkLvl;

  // pin decoding; dedicated use required for strobe and clock
  assign strobeLvl = pin0Dedicated & state.pin0Sync[1]; // RQ10
  assign clkLvl    = pin1Dedicated & state.pin1Sync[1]; // RQ11
  assign csHigh    = state.pin2Sync[1];
  // pulsing strobe = either edge, or any level that differs from the idle polarity
  assign strobeAct = pin0Dedicated & ((strobeLvl ^ state.pin0Last)
                     | (strobeLvl != strobeIdleLevel));
  assign clkRise   = clkLvl & ~state.pin1Last; // RQ17

  asu_idle_counter idleCounter (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .enable         (pwrReg0[APD_EN_BIT]), // RQ14
    .strobeActivity (strobeAct),
    .clkRise        (clkRise),
    .sleepAssert    (counterSleep)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_state = state;
    next_state.pin0Sync = {state.pin0Sync[0], portdPin0};
    next_state.pin1Sync = {state.pin1Sync[0], portdPin1};
    next_state.pin2Sync = {state.pin2Sync[0], portdPin2};
    next_state.pin0Last = strobeLvl;
    next_state.pin1Last = clkLvl;
    next_state.wasReset = 1'b0;
    next_pwrReg0 = pwrReg0;
    next_pwrReg2 = pwrReg2;
    // run-time register writes, regSel picks register 2
    if (regWrite && !state.sleep) begin
      if (regSel) begin
        next_pwrReg2 = regWdata; // RQ7
      end else begin
        next_pwrReg0 = regWdata; // RQ8
      end
    end
    // enter on counter, leave on strobe, chip select low, reset release or auto sleep disabled
    if (counterSleep && !strobeAct) begin
      next_state.sleep = 1'b1; // RQ1
    end
    if (strobeAct || !csHigh || state.wasReset || !pwrReg0[APD_EN_BIT]) begin
      next_state.sleep = 1'b0; // RQ13
    end
    // gate host bus: hold last value so memories see no transition
    if (!state.sleep) begin
      next_state.memOut = hostBus; // RQ2
    end
    next_state.busLast = next_state.memOut;
    // array inputs with blocking bits; counter clock is not affected
    next_state.pldOut.strobe = strobeLvl & ~pwrReg2[BLK_STROBE_BIT] & ~state.sleep; // RQ7
    next_state.pldOut.clk    = clkLvl & ~pwrReg0[CLK_BLOCK_BIT]; // RQ14
    next_state.pldOut.cntl0  = cntl0 & ~pwrReg2[BLK_CNTL0_BIT];
    next_state.pldOut.cntl1  = cntl1 & ~pwrReg2[BLK_CNTL1_BIT];
    next_state.pldOut.cntl2  = cntl2 & ~pwrReg2[BLK_CNTL2_BIT];
    next_state.pldOut.dbe    = dbe & ~pwrReg2[BLK_DBE_BIT];
    next_state.pldLastChg    = (next_state.pldOut != state.pldOut); // RQ3
  end

  // ************************************************************
  // registers
  // ************************************************************
  // power registers keep contents across rst; only power-on clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state.pin0Sync   <= 2'h0;
      state.pin1Sync   <= 2'h0;
      state.pin2Sync   <= 2'h3;
      state.pin0Last   <= 1'b0;
      state.pin1Last   <= 1'b0;
      state.busLast    <= '0;
      state.memOut     <= '0;
      state.pldOut     <= '0;
      state.pldLastChg <= 1'b0;
      state.sleep      <= 1'b0;
      state.wasReset   <= 1'b1;
    end else begin
      state.pin0Sync   <= next_state.pin0Sync;
      state.pin1Sync   <= next_state.pin1Sync;
      state.pin2Sync   <= next_state.pin2Sync;
      state.pin0Last   <= next_state.pin0Last;
      state.pin1Last   <= next_state.pin1Last;
      state.busLast    <= next_state.busLast;
      state.memOut     <= next_state.memOut;
      state.pldOut     <= next_state.pldOut;
      state.pldLastChg <= next_state.pldLastChg;
      state.sleep      <= next_state.sleep;
      state.wasReset   <= next_state.wasReset;
    end
  end

  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      pwrReg0 <= PWR_REG_RESET; // RQ15
      pwrReg2 <= PWR_REG_RESET;
    end else begin
      pwrReg0 <= next_pwrReg0;
      pwrReg2 <= next_pwrReg2;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign memBus       = state.memOut;
  assign pldIn        = state.pldOut;
  // chip select only affects memories, never the arrays
  assign flashSel     = ~csHigh & ~state.sleep; // RQ4
  assign sramSel      = ~csHigh & ~state.sleep; // RQ5
  assign ctlSpaceSel  = ~csHigh & ~state.sleep;
  // memory wakes only while its gated inputs move and it is selected
  assign memStandby   = ~flashSel | (state.busLast == hostBus) | state.sleep; // RQ6
  assign turboOn      = ~pwrReg0[TURBO_OFF_BIT]; // RQ8
  assign pldStandby   = pwrReg0[TURBO_OFF_BIT] & ~state.pldLastChg; // RQ9
  assign sleepState   = state.sleep;
  assign powerCtlReg0 = pwrReg0;
  assign powerCtlReg2 = pwrReg2;
endmodule // asu_auto_sleep_unit

// file: sim/asu_host_model.sv
// host model: address strobe and bus of the controller
`timescale 1ns/1ns
module asu_host_model (
  input  wire logic         ref_clk,
  input  wire logic         pulsing,
  input  wire logic         idleLevel,
  output logic              strobe,
  output asu_pkg::asu_bus_t hostBus
);
  import asu_pkg::*;
  logic [15:0] lfsr;
  initial begin
    lfsr = 16'h1d3b;
    strobe = 1'b1;
    hostBus = '0;
  end
  // strobe toggles while busy and rests at the idle level otherwise;
  // the bus never rests, as other devices share it
  always @(posedge ref_clk) begin
    lfsr <= #10 {lfsr[14:0], lfsr[15] ^ lfsr[13]};
    strobe <= #10 pulsing ? ~strobe : idleLevel;
    hostBus <= #10 lfsr;
  end
endmodule // asu_host_model

// file: sim/asu_sleep_asserts.sv
// checker: sleep entry, exit, gating and register writes
`timescale 1ns/1ns
module asu_sleep_asserts (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 portdPin0,
  input wire logic                 portdPin1,
  input wire logic                 portdPin2,
  input wire logic                 regWrite,
  input wire logic                 regSel,
  input wire logic [7:0]           regWdata,
  input wire asu_pkg::asu_bus_t    memBus,
  input wire asu_pkg::asu_pld_in_t pldIn,
  input wire logic                 flashSel,
  input wire logic                 sramSel,
  input wire logic                 ctlSpaceSel,
  input wire logic                 turboOn,
  input wire logic                 sleepState,
  input wire logic [7:0]           powerCtlReg0,
  input wire logic [7:0]           powerCtlReg2
);
  import asu_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [4:0] riseCnt;
  logic       lastClk;
  logic       lastStb;
  // raw pin count leads the synced one, so it is a safe upper bound
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      riseCnt <= 5'h00;
      lastClk <= 1'b0;
      lastStb <= 1'b0;
    end else begin
      lastClk <= portdPin1;
      lastStb <= portdPin0;
      if (portdPin0 != lastStb) riseCnt <= 5'h00;
      else if (portdPin1 && !lastClk && riseCnt != 5'h1f) riseCnt <= riseCnt + 5'h01;
    end
  end
  sequence clkBlocked; powerCtlReg0[CLK_BLOCK_BIT] [*3]; endsequence
  sequence csHeldLow; !portdPin2 [*5]; endsequence
  sleep_deselect_a: assert property (sleepState |-> !flashSel && !sramSel && !ctlSpaceSel)
    else $error("memory selected in sleep");
  sleep_freeze_a: assert property (sleepState && $past(sleepState) |-> $stable(memBus))
    else $error("memory bus moved in sleep");
  cs_deselect_a: assert property (portdPin2 [*4] |-> !flashSel && !sramSel && !ctlSpaceSel)
    else $error("memory selected with chip select high");
  cs_wake_a: assert property (csHeldLow |-> !sleepState)
    else $error("sleep held with chip select low");
  turbo_bit_a: assert property (turboOn == !powerCtlReg0[TURBO_OFF_BIT])
    else $error("turbo flag wrong");
  write_reg0_a: assert property (regWrite && !regSel && !sleepState |=> powerCtlReg0 == $past(regWdata))
    else $error("register 0 write lost");
  write_reg2_a: assert property (regWrite && regSel && !sleepState |=> powerCtlReg2 == $past(regWdata))
    else $error("register 2 write lost");
  sleep_ignore_a: assert property (regWrite && sleepState |=> $stable(powerCtlReg0) && $stable(powerCtlReg2))
    else $error("register written in sleep");
  idle_count_a: assert property ($rose(sleepState) |-> riseCnt >= 5'd15)
    else $error("sleep before fifteen periods");
  clk_block_a: assert property (clkBlocked |-> $stable(pldIn.clk))
    else $error("blocked clock reached arrays");
  no_enable_a: assert property (!powerCtlReg0[APD_EN_BIT] [*4] |-> !sleepState)
    else $error("sleep while disabled");
endmodule // asu_sleep_asserts

// file: sim/tb_top.sv
// testbench: auto sleep unit driven by a host model
`timescale 1ns/1ns
module tb_top;
  import asu_pkg::*;
  logic ref_clk = 0, rst = 1, porN = 0, pulsing = 1, idleLvl = 1, csN = 0, cclk = 0;
  logic regWrite = 0, regSel = 0, cntl0 = 0, cntl1 = 0, cntl2 = 0, dbe = 0;
  logic [7:0]  regWdata = 8'h00, d, sh0, sh2;
  logic [31:0] seed = 32'hac28;
  logic        strobe, flashSel, sramSel, ctlSpaceSel, memStandby, pldStandby, turboOn, sleepState;
  logic [7:0]  powerCtlReg0, powerCtlReg2;
  asu_bus_t    hostBus, memBus;
  asu_pld_in_t pldIn;
  int          fails = 0, samples_checked = 0;
  asu_host_model asu_host_model_i (.ref_clk, .pulsing, .idleLevel(idleLvl), .strobe, .hostBus);
  asu_auto_sleep_unit asu_auto_sleep_unit_i (.ref_clk, .rst, .porN, .pin0Dedicated(1'b1),
    .pin1Dedicated(1'b1), .portdPin0(strobe), .portdPin1(cclk), .portdPin2(csN),
    .strobeIdleLevel(idleLvl), .regWrite, .regSel, .regWdata, .hostBus, .cntl0, .cntl1,
    .cntl2, .dbe, .memBus, .pldIn, .flashSel, .sramSel, .ctlSpaceSel, .memStandby,
    .pldStandby, .turboOn, .sleepState, .powerCtlReg0, .powerCtlReg2);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  // one common clock period spans four reference cycles
  task automatic tick(input int n);
    repeat (n) begin
      cclk = 1;
      cyc(2);
      cclk = 0;
      cyc(2);
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] v);
    regSel = sel;
    regWdata = v;
    regWrite = 1;
    cyc(1);
    regWrite = 0;
  endtask
  // bounded wait for a sleep state; running out ends the run
  task automatic waitSleep(input logic v, input int bound);
    for (int i = 0; i < bound && sleepState !== v; i++) tick(1);
    check(sleepState === v, "sleep state");
    if (sleepState !== v) give_verdict();
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    cyc(5);
    rst = 0;
    porN = 1;
    cyc(2);
    check(powerCtlReg0 === PWR_REG_RESET && powerCtlReg2 === PWR_REG_RESET, "reset");
    check(turboOn === 1'b1, "turbo default");
    for (int r = 0; r < 2; r++) begin
      idleLvl = ~r[0];
      wr(0, 8'h02);
      pulsing = 0;
      csN = 1;
      tick(12);
      check(sleepState === 1'b0, "slept early");
      waitSleep(1, 8);
      check(memStandby === 1'b1 && flashSel === 1'b0, "memory awake in sleep");
      wr(1, 8'h7c);
      check(powerCtlReg2 === 8'h00, "write in sleep");
      pulsing = 1;
      waitSleep(0, 4);
      pulsing = 0;
      waitSleep(1, 20);
      csN = 0;
      waitSleep(0, 4);
      csN = 1;
      waitSleep(1, 20);
      rst = 1;
      cyc(1);
      rst = 0;
      cyc(1);
      check(sleepState === 1'b0 && powerCtlReg0 === 8'h02, "reset exit");
      $display("sleep round %0d done", r);
    end
    sh0 = 8'h02;
    sh2 = 8'h00;
    pulsing = 1;
    for (int k = 0; k < 300; k++) begin
      seed = xs(seed);
      {cntl0, cntl1, cntl2, dbe, csN, cclk} = seed[5:0];
      d = seed[15:8] & (seed[16] ? 8'h7c : 8'h1a);
      wr(seed[16], d);
      if (seed[16]) sh2 = d;
      else sh0 = d;
      cyc(1);
      check(powerCtlReg0 === sh0 && powerCtlReg2 === sh2, "register");
      check(turboOn === ~sh0[TURBO_OFF_BIT], "turbo");
      check(flashSel === ~csN && sramSel === ~csN && ctlSpaceSel === ~csN, "chip select");
      check(pldIn.cntl0 === (cntl0 & ~sh2[BLK_CNTL0_BIT]), "cntl0 block");
      check(pldIn.cntl1 === (cntl1 & ~sh2[BLK_CNTL1_BIT]), "cntl1 block");
      check(pldIn.cntl2 === (cntl2 & ~sh2[BLK_CNTL2_BIT]), "cntl2 block");
      check(pldIn.dbe === (dbe & ~sh2[BLK_DBE_BIT]), "dbe block");
      if (!sh0[TURBO_OFF_BIT]) check(pldStandby === 1'b0, "standby with turbo on");
    end
    $display("random writes done");
    give_verdict();
  end
endmodule // tb_top
bind asu_auto_sleep_unit asu_sleep_asserts asu_sleep_asserts_i (.ref_clk, .rst, .portdPin0,
  .portdPin1, .portdPin2, .regWrite, .regSel, .regWdata, .memBus, .pldIn, .flashSel,
  .sramSel, .ctlSpaceSel, .turboOn, .sleepState, .powerCtlReg0, .powerCtlReg2);
